/* File: core/nvsp_params.svh */
// Timing and geometry constants for the nonvolatile static memory host port
`ifndef NVSP_PARAMS_SVH
`define NVSP_PARAMS_SVH
`define NVSP_CLK_PERIOD_NS 50
`define NVSP_ADDR_W 15
`define NVSP_DATA_W 8
`define NVSP_CYCLE_FAST_NS 25
`define NVSP_CYCLE_SLOW_NS 45
`define NVSP_CYCLE_NS(slow) ((slow) ? `NVSP_CYCLE_SLOW_NS : `NVSP_CYCLE_FAST_NS)
`define NVSP_CYC_UP(ns) ((((ns) + `NVSP_CLK_PERIOD_NS - 1) / `NVSP_CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `NVSP_CLK_PERIOD_NS - 1) / `NVSP_CLK_PERIOD_NS))
`define NVSP_SAVE_PULSE_NS 15
`define NVSP_SEQ_PROC_US 100
`define NVSP_RESTORE_MS 20
`define NVSP_SEQ_LEN 6
`endif

/* File: core/nvsp_pkg.sv */
// Types for the nonvolatile static memory host port
package nvsp_pkg;
    typedef enum logic [2:0] {
        NVSP_IDLE = 3'b000,
        NVSP_ACCESS = 3'b001,
        NVSP_RECOVER = 3'b010,
        NVSP_SAVE_PULSE = 3'b011,
        NVSP_BUSY_WAIT = 3'b100,
        NVSP_SEQ_WAIT = 3'b101,
        NVSP_POWER_WAIT = 3'b110
    } nvsp_state_t;
    typedef enum logic [1:0] {
        NVSP_CMD_READ = 2'b00,
        NVSP_CMD_WRITE = 2'b01,
        NVSP_CMD_SAVE = 2'b10,
        NVSP_CMD_SEQ_READ = 2'b11
    } nvsp_cmd_t;
endpackage : nvsp_pkg

/* File: core/nvsp_host.sv */
// Host controller driving a battery-free nonvolatile static memory over its pins
`timescale 1ns/1ns
`default_nettype none
`include "nvsp_params.svh"

//////////////////////////////////////////////////////////////////////////////
module nvsp_host #(
    parameter int ADDR_W = `NVSP_ADDR_W,
    parameter int DATA_W = `NVSP_DATA_W,
    parameter bit SLOW_GRADE = 1'b0,
    parameter int RESTORE_CYC = (`NVSP_RESTORE_MS * 1000000) / `NVSP_CLK_PERIOD_NS,
    parameter int SEQ_PROC_CYC = (`NVSP_SEQ_PROC_US * 1000) / `NVSP_CLK_PERIOD_NS
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic req_valid_in,
    input wire nvsp_pkg::nvsp_cmd_t req_cmd_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    input wire logic supply_ok_in,
    output logic req_ready_out,
    output logic resp_valid_out,
    output logic [DATA_W-1:0] resp_rdata_out,
    output logic resp_trust_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic chip_sel_n_out,
    output logic write_strobe_n_out,
    output logic out_strobe_n_out,
    input wire logic [DATA_W-1:0] mem_dq_in,
    output logic [DATA_W-1:0] mem_dq_out,
    output logic mem_dq_oe_n_out,
    input wire logic save_busy_pin_n_in,
    output logic save_busy_pin_n_out,
    output logic save_busy_pin_n_oe_n_out
);
    import nvsp_pkg::*;

    localparam int CYC_W = 20;
    localparam int ACC_CYC = `NVSP_CYC_UP(`NVSP_CYCLE_NS(SLOW_GRADE));
    localparam int PULSE_CYC = `NVSP_CYC_UP(`NVSP_SAVE_PULSE_NS);
    localparam int SEQ_LEN = `NVSP_SEQ_LEN;

    // Refuse widths and wait counts the logic cannot serve
    if (ADDR_W != 15 || DATA_W != 8) begin : g_bad_width
        $error("nvsp_host: bus widths must be 15 and 8");
    end
    if (RESTORE_CYC < 1 || RESTORE_CYC >= (1 << CYC_W) || SEQ_PROC_CYC < 1
        || SEQ_PROC_CYC >= (1 << CYC_W)) begin : g_bad_count
        $error("nvsp_host: wait counts out of range");
    end

    // Saturating decrement used by the cycle counter cnt_reg
    function automatic logic [CYC_W-1:0] dec_sat(input logic [CYC_W-1:0] v);
        dec_sat = (v == '0) ? '0 : v - 1'b1;
    endfunction : dec_sat

    nvsp_state_t state_reg, state_next;
    nvsp_cmd_t cmd_reg;
    logic [CYC_W-1:0] cnt_reg, cnt_next;
    logic [2:0] seq_cnt_reg;

    //////////////////////////////////////////////////////////////////////////
    // Decoding
    wire logic device_blocked = ~supply_ok_in | ~save_busy_pin_n_in;
    wire logic take = (state_reg == NVSP_IDLE) && req_valid_in && !device_blocked;
    wire logic is_write = (cmd_reg == NVSP_CMD_WRITE);
    wire logic is_seq = (cmd_reg == NVSP_CMD_SEQ_READ);
    wire logic cnt_done = (cnt_reg == '0);
    wire logic last_seq = is_seq && (seq_cnt_reg == 3'(SEQ_LEN - 1));

    // Next-state selection
    always_comb begin
        state_next = state_reg;
        cnt_next = dec_sat(cnt_reg);
        case (state_reg)
            NVSP_POWER_WAIT: begin
                // restore wait timed from supply good
                if (!supply_ok_in) cnt_next = CYC_W'(RESTORE_CYC);
                else if (cnt_done) state_next = NVSP_IDLE;
            end
            NVSP_IDLE: begin
                // hold off while device is busy or supply low
                if (!supply_ok_in) begin
                    state_next = NVSP_POWER_WAIT;
                    cnt_next = CYC_W'(RESTORE_CYC);
                end else if (take && req_cmd_in == NVSP_CMD_SAVE) begin
                    state_next = NVSP_SAVE_PULSE;
                    cnt_next = CYC_W'(PULSE_CYC - 1);
                end else if (take) begin
                    state_next = NVSP_ACCESS;
                    cnt_next = CYC_W'(ACC_CYC - 1);
                end
            end
            NVSP_ACCESS: if (cnt_done) state_next = NVSP_RECOVER;
            NVSP_RECOVER: begin
                // wait for the device to act on a finished sequence
                if (last_seq) begin
                    state_next = NVSP_SEQ_WAIT;
                    cnt_next = CYC_W'(SEQ_PROC_CYC);
                end else state_next = NVSP_IDLE;
            end
            NVSP_SAVE_PULSE: if (cnt_done) state_next = NVSP_BUSY_WAIT;
            NVSP_BUSY_WAIT: begin
                // device releases pin high; skipped save ends quickly
                if (save_busy_pin_n_in) state_next = NVSP_IDLE;
            end
            NVSP_SEQ_WAIT: begin
                // bus held idle until the wait count ends and busy pin returns high
                if (cnt_done && save_busy_pin_n_in) state_next = NVSP_IDLE;
            end
            default: state_next = NVSP_POWER_WAIT;
        endcase
    end

    // State and counters
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_reg <= NVSP_POWER_WAIT;
            cnt_reg <= CYC_W'(RESTORE_CYC);
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // Command capture and sequence position
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cmd_reg <= NVSP_CMD_READ;
            seq_cnt_reg <= 3'h0;
            mem_addr_out <= '0;
            mem_dq_out <= '0;
        end else if (take) begin
            cmd_reg <= req_cmd_in;
            mem_addr_out <= req_addr_in;
            mem_dq_out <= req_wdata_in;
        end else if (state_reg == NVSP_RECOVER) begin
            if (is_seq && !last_seq) seq_cnt_reg <= seq_cnt_reg + 3'h1;
            else seq_cnt_reg <= 3'h0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Memory pins; address only changes in idle with select high
    wire logic in_access = (state_next == NVSP_ACCESS);
    wire logic wr_access = in_access && ((state_reg == NVSP_IDLE) ?
        (req_cmd_in == NVSP_CMD_WRITE) : is_write);
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            chip_sel_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            out_strobe_n_out <= 1'b1;
            mem_dq_oe_n_out <= 1'b1;
        end else begin
            // reads timed by chip select and output strobe
            // active-low strobes; write strobe high on reads
            chip_sel_n_out <= !in_access;
            write_strobe_n_out <= !wr_access;
            out_strobe_n_out <= !(in_access && !wr_access);
            mem_dq_oe_n_out <= !wr_access;
        end
    end

    // Save/busy pin: driven low only for the save pulse
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            save_busy_pin_n_out <= 1'b1;
            save_busy_pin_n_oe_n_out <= 1'b1;
        end else begin
            save_busy_pin_n_out <= 1'b0;
            save_busy_pin_n_oe_n_out <= !(state_next == NVSP_SAVE_PULSE);
        end
    end

    // Response; data sampled at end of access, sixth sequence read untrusted
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            resp_valid_out <= 1'b0;
            resp_rdata_out <= '0;
            resp_trust_out <= 1'b0;
            req_ready_out <= 1'b0;
        end else begin
            resp_valid_out <= (state_reg == NVSP_ACCESS) && cnt_done && !is_write;
            if ((state_reg == NVSP_ACCESS) && cnt_done && !is_write) begin
                resp_rdata_out <= mem_dq_in;
                resp_trust_out <= !last_seq;
            end
            req_ready_out <= (state_next == NVSP_IDLE);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    // Lengths of the current select and save pulse, saturating
    logic [3:0] sel_len_reg;
    logic [3:0] pulse_len_reg;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sel_len_reg <= 4'h0;
            pulse_len_reg <= 4'h0;
        end else begin
            sel_len_reg <= chip_sel_n_out ? 4'h0 : sel_len_reg + {3'h0, sel_len_reg != 4'hf};
            pulse_len_reg <= save_busy_pin_n_oe_n_out ? 4'h0 :
                pulse_len_reg + {3'h0, pulse_len_reg != 4'hf};
        end
    end
    a_access_len: assert property (@(posedge clock_in) disable iff (srst_in)
        $rose(chip_sel_n_out) |-> (sel_len_reg >= 4'(ACC_CYC)))
        else $error("access shorter than cycle time");
    // write strobe high with output strobe low
    a_read_we_high: assert property (@(posedge clock_in) disable iff (srst_in)
        !out_strobe_n_out |-> write_strobe_n_out)
        else $error("write strobe low during read");
    a_save_pulse: assert property (@(posedge clock_in) disable iff (srst_in)
        $rose(save_busy_pin_n_oe_n_out) |-> (pulse_len_reg >= 4'(PULSE_CYC)))
        else $error("save pulse too short");
    a_busy_idle: assert property (@(posedge clock_in) disable iff (srst_in)
        !chip_sel_n_out |-> save_busy_pin_n_oe_n_out)
        else $error("save pin driven during access");
    a_addr_stable: assert property (@(posedge clock_in) disable iff (srst_in)
        (!chip_sel_n_out && !$past(chip_sel_n_out)) |-> $stable(mem_addr_out))
        else $error("address moved while selected");
    a_no_low_access: assert property (@(posedge clock_in) disable iff (srst_in)
        (!supply_ok_in && state_reg == NVSP_IDLE) |=> chip_sel_n_out)
        else $error("access started on low supply");
    // write strobe high through sequence reads
    a_seq_we_high: assert property (@(posedge clock_in) disable iff (srst_in)
        (is_seq && !chip_sel_n_out) |-> write_strobe_n_out)
        else $error("write strobe low in sequence");
    a_seq_lock: assert property (@(posedge clock_in) disable iff (srst_in)
        (state_reg == NVSP_SEQ_WAIT) |=> chip_sel_n_out)
        else $error("bus used during sequence wait");
endmodule : nvsp_host
`default_nettype wire

/* File: dv/nvsp_mem_model.sv */
// Behavioural model of the nonvolatile static memory device
`timescale 1ns/1ns
`default_nettype none
module nvsp_mem_model #(
    parameter int BUSY_CYC = 6,
    parameter logic [14:0] SEQ_BASE = 15'h7ff0
) (
    input wire logic clock_in,
    input wire logic supply_ok_in,
    input wire logic [14:0] addr_in,
    input wire logic chip_sel_n_in,
    input wire logic write_strobe_n_in,
    input wire logic out_strobe_n_in,
    input wire logic [7:0] host_dq_in,
    input wire logic host_dq_oe_n_in,
    input wire logic pin_oe_n_in,
    input wire logic pin_val_in,
    output logic [7:0] dq_out,
    output logic pin_out
);
    logic [7:0] mem_reg [0:32767];
    logic [7:0] last_reg = 8'h00;
    logic latch_reg = 1'b0;
    logic busy_reg = 1'b0;
    logic supply_q_reg = 1'b0;
    logic sel_q_reg = 1'b1;
    logic [2:0] seq_pos_reg = 3'h0;
    int cnt_reg = 0;
    // locked during store, restore and low supply
    wire locked = busy_reg || !supply_ok_in;
    // drive only on a proper read
    wire drive = !chip_sel_n_in && write_strobe_n_in && !out_strobe_n_in && !locked;
    // First sampled edge of a selection, and of a read
    wire sel_start = !chip_sel_n_in && sel_q_reg;
    wire rd_start = sel_start && write_strobe_n_in && !out_strobe_n_in && !locked;
    // read of the next command address in order
    wire seq_hit = rd_start && (addr_in == SEQ_BASE + 15'(seq_pos_reg));
    wire seq_go = seq_hit && (seq_pos_reg == 3'h5);
    // restore busy once supply rises above threshold
    wire restore_go = supply_ok_in && !supply_q_reg;
    // pin save only when a write is latched
    wire save_go = !busy_reg && !pin_oe_n_in && !pin_val_in && latch_reg;
    // Bus level: host, device, else a pattern that flips each cycle
    assign dq_out = !host_dq_oe_n_in ? host_dq_in : drive ? mem_reg[addr_in] : ~last_reg;
    // low drive ends with busy, pull-up holds after
    assign pin_out = !pin_oe_n_in ? pin_val_in : !busy_reg;
    // Write capture, store trigger and busy count
    always @(posedge clock_in) begin
        last_reg <= dq_out;
        supply_q_reg <= supply_ok_in;
        sel_q_reg <= chip_sel_n_in;
        // write on the edge that starts a save still lands
        if (!chip_sel_n_in && !write_strobe_n_in && !locked) begin
            mem_reg[addr_in] <= host_dq_in;
            latch_reg <= 1'b1;
        end
        // any other selection breaks the command sequence
        if (sel_start) seq_pos_reg <= (seq_hit && !seq_go) ? seq_pos_reg + 3'h1 : 3'h0;
        // restore, pin save or command locks the bus
        if (restore_go || save_go || seq_go) begin
            busy_reg <= 1'b1;
            cnt_reg <= BUSY_CYC;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 1;
            busy_reg <= cnt_reg > 1;
            latch_reg <= 1'b0;
        end
    end
endmodule : nvsp_mem_model
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the nonvolatile memory host port
`timescale 1ns/1ns
`default_nettype none
module tb;
    import nvsp_pkg::*;
    logic clock_in = 1'b0, srst_in = 1'b1, req_valid_in = 1'b0, supply_ok_in = 1'b1;
    nvsp_cmd_t req_cmd_in = NVSP_CMD_READ;
    logic [14:0] req_addr_in = 15'h0000, mem_addr_out, adr [8];
    logic [7:0] req_wdata_in = 8'h00, resp_rdata_out, mem_dq_in, mem_dq_out, dat [8], rd;
    logic req_ready_out, resp_valid_out, resp_trust_out, chip_sel_n_out, write_strobe_n_out;
    logic out_strobe_n_out, mem_dq_oe_n_out, pin, pin_oe_n, pin_val, tr;
    localparam logic [14:0] SEQ_BASE = 15'h7ff0;
    logic [31:0] lfsr = 32'h0000_15a8;
    int err_count = 0, checks = 0, low_cnt = 0, base;
    always #25 clock_in = ~clock_in;
    nvsp_host #(.RESTORE_CYC(4), .SEQ_PROC_CYC(4)) dut (.clock_in(clock_in),
        .srst_in(srst_in), .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in),
        .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .supply_ok_in(supply_ok_in),
        .req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out),
        .resp_rdata_out(resp_rdata_out), .resp_trust_out(resp_trust_out),
        .mem_addr_out(mem_addr_out), .chip_sel_n_out(chip_sel_n_out),
        .write_strobe_n_out(write_strobe_n_out), .out_strobe_n_out(out_strobe_n_out),
        .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe_n_out(mem_dq_oe_n_out),
        .save_busy_pin_n_in(pin), .save_busy_pin_n_out(pin_val),
        .save_busy_pin_n_oe_n_out(pin_oe_n));
    nvsp_mem_model #(.SEQ_BASE(SEQ_BASE)) dev (.clock_in(clock_in), .supply_ok_in(supply_ok_in),
        .addr_in(mem_addr_out), .chip_sel_n_in(chip_sel_n_out),
        .write_strobe_n_in(write_strobe_n_out), .out_strobe_n_in(out_strobe_n_out),
        .host_dq_in(mem_dq_out), .host_dq_oe_n_in(mem_dq_oe_n_out),
        .pin_oe_n_in(pin_oe_n), .pin_val_in(pin_val), .dq_out(mem_dq_in), .pin_out(pin));
    //////////////////////////////////////////////////////////////////////////////
    // Stimulus source and expected trust flag
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    function automatic logic exp_trust(input int i);
        return i != 5;
    endfunction : exp_trust
    task automatic check_bit(input string name, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %b, seen %b", name, e, g);
        end
    endtask : check_bit
    task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, e, g);
        end
    endtask : check_byte
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    // One request: wait for idle, hold one edge, collect read answer
    task automatic do_req(input nvsp_cmd_t c, input logic [14:0] a, input logic [7:0] d);
        int n = 0;
        @(negedge clock_in);
        req_cmd_in = c;
        req_addr_in = a;
        req_wdata_in = d;
        req_valid_in = 1'b1;
        while (!(req_ready_out === 1'b1 && pin === 1'b1) && n < 2000) begin
            @(negedge clock_in);
            n++;
        end
        check_bit("req_taken", 1'b1, n < 2000);
        @(negedge clock_in);
        req_valid_in = 1'b0;
        n = 0;
        if (c == NVSP_CMD_READ || c == NVSP_CMD_SEQ_READ) begin
            while (resp_valid_out !== 1'b1 && n < 20) begin
                @(negedge clock_in);
                n++;
            end
            rd = resp_rdata_out;
            tr = resp_trust_out;
            check_bit("resp_valid", 1'b1, resp_valid_out);
        end
    endtask : do_req
    //////////////////////////////////////////////////////////////////////////////
    // Pin monitors during selected cycles
    always @(negedge clock_in) if (chip_sel_n_out === 1'b0) begin
        check_bit("pin_released", 1'b1, pin_oe_n);
        if (out_strobe_n_out === 1'b0) check_bit("we_in_read", 1'b1, write_strobe_n_out);
    end
    always @(posedge clock_in) if (pin === 1'b0) low_cnt <= low_cnt + 1;
    // Main sequence
    initial begin
        repeat (4) @(negedge clock_in);
        srst_in = 1'b0;
        @(negedge clock_in);
        check_bit("ready_in_restore", 1'b0, req_ready_out);
        for (int i = 0; i < 8; i++) begin
            lfsr = next_rand(lfsr);
            adr[i] = {lfsr[14:3], i[2:0]};
            dat[i] = lfsr[22:15];
            do_req(NVSP_CMD_WRITE, adr[i], dat[i]);
        end
        for (int i = 0; i < 8; i++) begin
            do_req(NVSP_CMD_READ, adr[i], 8'h00);
            check_byte("read_data", dat[i], rd);
        end
        supply_ok_in = 1'b0;
        req_valid_in = 1'b1;
        repeat (6) begin
            @(negedge clock_in);
            check_bit("cs_low_supply", 1'b1, chip_sel_n_out);
        end
        supply_ok_in = 1'b1;
        do_req(NVSP_CMD_READ, adr[1], 8'h00);
        check_byte("read_after_supply", dat[1], rd);
        dat[0] = ~dat[0];
        do_req(NVSP_CMD_WRITE, adr[0], dat[0]);
        base = low_cnt;
        do_req(NVSP_CMD_SAVE, adr[0], 8'h00);
        do_req(NVSP_CMD_READ, adr[0], 8'h00);
        check_byte("read_after_save", dat[0], rd);
        check_bit("save_busy_seen", 1'b1, low_cnt - base > 1);
        base = low_cnt;
        do_req(NVSP_CMD_SAVE, adr[0], 8'h00);
        do_req(NVSP_CMD_READ, adr[2], 8'h00);
        check_byte("read_after_skip", dat[2], rd);
        check_bit("save_pulse_only", 1'b1, low_cnt - base == 1);
        for (int i = 0; i < 6; i++) begin
            do_req(NVSP_CMD_SEQ_READ, SEQ_BASE + 15'(i), 8'h00);
            check_bit("seq_trust", exp_trust(i), tr);
        end
        do_req(NVSP_CMD_READ, adr[3], 8'h00);
        check_byte("read_after_seq", dat[3], rd);
        summarize();
    end
    // Watchdog well past the expected run length
    initial begin
        #(50 * 20000);
        err_count++;
        summarize();
    end
endmodule : tb
`default_nettype wire
